// File: hdl/svm_pkg.sv
// constants for the vlan and meter configuration bank
package svm_pkg;
  localparam int AW = 8;
  localparam int DW = 16;
  localparam logic [AW-1:0] OFS_RSV_A_FIRST = 8'h23;
  localparam logic [AW-1:0] OFS_RSV_A_LAST = 8'h27;
  localparam logic [AW-1:0] OFS_P0_VID_HI = 8'h28;
  localparam logic [AW-1:0] OFS_P1_VID_HI = 8'h29;
  localparam logic [AW-1:0] OFS_P2_VID_HI = 8'h2a;
  localparam logic [AW-1:0] OFS_P34_VID_HI = 8'h2b;
  localparam logic [AW-1:0] OFS_P5_SHIFT_DA = 8'h2c;
  localparam logic [AW-1:0] OFS_RSV_B = 8'h2d;
  localparam logic [AW-1:0] OFS_RSV_C = 8'h2e;
  localparam logic [AW-1:0] OFS_RESTART = 8'h2f;
  localparam logic [AW-1:0] OFS_MISC = 8'h30;
  localparam logic [AW-1:0] OFS_METER = 8'h31;
  localparam logic [DW-1:0] RST_ZERO = 16'h0000;
  localparam logic [DW-1:0] RST_RSV_B = 16'h4442;
  localparam logic [DW-1:0] RST_SHIFT_DA = 16'hb000;
  localparam logic [DW-1:0] RST_MISC = 16'h0987;
  localparam logic [DW-1:0] RESTART_CMD = 16'h0000;
  localparam int SHIFT_LSB = 8;
  localparam int DA_FWD_HI_RANGE = 12;
  localparam int DA_FWD_LO_RANGE = 13;
  localparam int DA_FWD_01 = 14;
  localparam int DA_FWD_00 = 15;
  localparam int MISC_CLONE_HI = 5;
  localparam int MISC_MII_DOUBLE = 6;
  localparam int MISC_DUAL_HUB = 9;
  localparam int MISC_P4_LED = 12;
  localparam int METER_FIELD_W = 4;
  localparam int NPORTS = 6;
  localparam int NMETER = 4;
  localparam logic [39:0] RSV_DA_PREFIX = 40'h0180c20000;
  localparam logic [7:0] DA_LAST_00 = 8'h00;
  localparam logic [7:0] DA_LAST_01 = 8'h01;
  localparam logic [7:0] DA_LAST_0F = 8'h0f;
  localparam logic [7:0] DA_LAST_10 = 8'h10;
  // group membership bit positions of ports 0..5
  localparam int GRP_BIT [NPORTS] = '{0, 2, 4, 6, 7, 8};
  localparam int RATE_W = 17;
  // meter rate in kbit/s for threshold codes 0..7
  function automatic logic [RATE_W-1:0] svm_rate_kbps(input logic [2:0] code);
    case (code)
      3'h0: svm_rate_kbps = 17'h00100;
      3'h1: svm_rate_kbps = 17'h00200;
      3'h2: svm_rate_kbps = 17'h003e8;
      3'h3: svm_rate_kbps = 17'h007d0;
      3'h4: svm_rate_kbps = 17'h01388;
      3'h5: svm_rate_kbps = 17'h02710;
      3'h6: svm_rate_kbps = 17'h04e20;
      default: svm_rate_kbps = 17'h0c350;
    endcase
  endfunction
endpackage

// File: hdl/svm_vid_join.sv
// joins the high and low default vlan id parts of one port
module svm_vid_join import svm_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] vid_hi_in,
  input wire logic [3:0] vid_lo_in,
  output logic [11:0] vid_out
);
  typedef struct packed {
    logic [11:0] vid;
  } svm_vj_t;
  svm_vj_t s_q;
  svm_vj_t s_d;
  always_comb begin
    s_d = s_q;
    s_d.vid = {vid_hi_in, vid_lo_in};
  end
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign vid_out = s_q.vid;
  a_vid_join_order: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    vid_out == $past({vid_hi_in, vid_lo_in}))
    else $error("default vlan id halves joined wrongly");
endmodule

// File: hdl/svm_meter_gate.sv
// per-port meter threshold, gated by the port's bandwidth enable
module svm_meter_gate import svm_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [METER_FIELD_W-1:0] field_in,
  input wire logic enable_in,
  output logic [RATE_W-1:0] rate_kbps_out,
  output logic active_out,
  output logic count_len_out
);
  typedef struct packed {
    logic [RATE_W-1:0] rate;
    logic active;
    logic count_len;
  } svm_mg_t;
  svm_mg_t s_q;
  svm_mg_t s_d;
  always_comb begin
    s_d = s_q;
    s_d.active = enable_in;
    s_d.rate = enable_in ? svm_rate_kbps(field_in[2:0]) : '0;
    s_d.count_len = !field_in[3];
  end
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign rate_kbps_out = s_q.rate;
  assign active_out = s_q.active;
  assign count_len_out = s_q.count_len;
  a_meter_gated: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    !active_out |-> rate_kbps_out == '0)
    else $error("meter rate applied while disabled");
endmodule

// File: hdl/svm_bank.sv
// vlan, reserved address, restart, misc and meter configuration bank
module svm_bank import svm_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DW-1:0] rdata_out,
  input wire logic [NPORTS*4-1:0] port_vid_low_in,
  input wire logic [8:0] group_map_in,
  input wire logic [11:0] frame_vid_in,
  input wire logic [47:0] dest_addr_in,
  input wire logic dest_valid_in,
  input wire logic clone_bit0_in,
  input wire logic [NMETER-1:0] bw_enable_in,
  input wire logic col_10m_in,
  input wire logic col_100m_in,
  input wire logic [1:0] port_col_in,
  output logic [NPORTS*12-1:0] port_default_vlan_id_out,
  output logic [NPORTS-1:0] group_ports_out,
  output logic [3:0] vlan_group_key_out,
  output logic dest_result_valid_out,
  output logic dest_reserved_out,
  output logic dest_forward_out,
  output logic transceiver_restart_out,
  output logic mii_speed_double_out,
  output logic [1:0] collision_indicator_led_out,
  output logic port4_led_mode_out,
  output logic [1:0] clone_mode_out,
  output logic [11:0] vlan_identifier_learning_key_out,
  output logic [NMETER*RATE_W-1:0] meter_rate_kbps_out,
  output logic [NMETER-1:0] meter_active_out,
  output logic [NMETER-1:0] count_len_out
);
  localparam int NRSV_A = 5;
  typedef struct packed {
    logic [NRSV_A-1:0][DW-1:0] rsv_a;
    logic [3:0][7:0] vid_hi;
    logic [7:0] vid_hi_p4;
    logic [DW-1:0] shift_da;
    logic [DW-1:0] rsv_b;
    logic [DW-1:0] rsv_c;
    logic [DW-1:0] restart;
    logic [DW-1:0] misc;
    logic [DW-1:0] meter;
    logic [DW-1:0] rdata;
    logic restart_p;
    logic res_valid;
    logic res_rsv;
    logic res_fwd;
    logic [NPORTS-1:0] grp;
    logic [3:0] key;
    logic [1:0] led;
    logic [11:0] learn_key;
    logic clone0;
  } svm_bank_t;

  svm_bank_t s_q;
  svm_bank_t s_d;
  logic [NPORTS-1:0][7:0] vid_hi_all;
  logic [NPORTS*12-1:0] vid_all;
  logic [AW-1:0] rsv_idx;

  assign vid_hi_all = {s_q.shift_da[7:0], s_q.vid_hi_p4, s_q.vid_hi[3], s_q.vid_hi[2],
                       s_q.vid_hi[1], s_q.vid_hi[0]};
  assign rsv_idx = addr_in - OFS_RSV_A_FIRST;

  always_comb begin
    logic [7:0] last;
    logic [11:0] shifted;
    last = dest_addr_in[7:0];
    shifted = '0;
    s_d = s_q;
    s_d.restart_p = 1'b0;
    s_d.rdata = '0;
    if (wr_in) begin
      case (addr_in)
        OFS_P0_VID_HI: s_d.vid_hi[0] = wdata_in[7:0];
        OFS_P1_VID_HI: s_d.vid_hi[1] = wdata_in[7:0];
        OFS_P2_VID_HI: s_d.vid_hi[2] = wdata_in[7:0];
        OFS_P34_VID_HI: begin
          s_d.vid_hi[3] = wdata_in[7:0];
          s_d.vid_hi_p4 = wdata_in[15:8];
        end
        OFS_P5_SHIFT_DA: s_d.shift_da = wdata_in;
        OFS_RSV_B: s_d.rsv_b = wdata_in;
        OFS_RSV_C: s_d.rsv_c = wdata_in;
        OFS_RESTART: begin
          s_d.restart = wdata_in;
          s_d.restart_p = (wdata_in == RESTART_CMD);
        end
        OFS_MISC: s_d.misc = wdata_in;
        OFS_METER: s_d.meter = wdata_in;
        default: begin
          if (addr_in >= OFS_RSV_A_FIRST && addr_in <= OFS_RSV_A_LAST) begin
            s_d.rsv_a[rsv_idx[2:0]] = wdata_in;
          end
        end
      endcase
    end
    if (rd_in) begin
      case (addr_in)
        OFS_P0_VID_HI: s_d.rdata = {8'h00, s_q.vid_hi[0]};
        OFS_P1_VID_HI: s_d.rdata = {8'h00, s_q.vid_hi[1]};
        OFS_P2_VID_HI: s_d.rdata = {8'h00, s_q.vid_hi[2]};
        OFS_P34_VID_HI: s_d.rdata = {s_q.vid_hi_p4, s_q.vid_hi[3]};
        OFS_P5_SHIFT_DA: s_d.rdata = s_q.shift_da;
        OFS_RSV_B: s_d.rdata = s_q.rsv_b;
        OFS_RSV_C: s_d.rdata = s_q.rsv_c;
        OFS_RESTART: s_d.rdata = s_q.restart;
        OFS_MISC: s_d.rdata = s_q.misc;
        OFS_METER: s_d.rdata = s_q.meter;
        default: begin
          if (addr_in >= OFS_RSV_A_FIRST && addr_in <= OFS_RSV_A_LAST) begin
            s_d.rdata = s_q.rsv_a[rsv_idx[2:0]];
          end
        end
      endcase
    end
    // group membership: pick the six port bits out of the nine-bit word
    for (int p = 0; p < NPORTS; p++) begin
      s_d.grp[p] = group_map_in[GRP_BIT[p]];
    end
    shifted = frame_vid_in >> s_q.shift_da[SHIFT_LSB +: 3];
    s_d.key = shifted[3:0];
    // reserved destination classification, one result per valid address
    s_d.res_valid = dest_valid_in;
    s_d.res_rsv = 1'b0;
    s_d.res_fwd = 1'b1;
    if (dest_valid_in && dest_addr_in[47:8] == RSV_DA_PREFIX) begin
      s_d.res_rsv = 1'b1;
      if (last == DA_LAST_00) begin
        s_d.res_fwd = s_q.shift_da[DA_FWD_00];
      end else if (last == DA_LAST_01) begin
        s_d.res_fwd = s_q.shift_da[DA_FWD_01];
      end else if (last <= DA_LAST_0F) begin
        s_d.res_fwd = s_q.shift_da[DA_FWD_LO_RANGE];
      end else begin
        s_d.res_fwd = s_q.shift_da[DA_FWD_HI_RANGE];
      end
    end
    // dual hub mode: led 0 tracks 10M collisions, led 1 tracks 100M
    if (s_q.misc[MISC_DUAL_HUB]) begin
      s_d.led = {col_100m_in, col_10m_in};
    end else begin
      s_d.led = port_col_in;
    end
    // registered so every bank output leaves a flop, at one cycle of latency
    s_d.clone0 = clone_bit0_in;
    // either clone enable bit turns on vlan-keyed learning
    if (clone_bit0_in || s_q.misc[MISC_CLONE_HI]) begin
      s_d.learn_key = frame_vid_in;
    end else begin
      s_d.learn_key = '0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q <= '0;
      s_q.shift_da <= RST_SHIFT_DA;
      s_q.rsv_b <= RST_RSV_B;
      s_q.restart <= RST_ZERO;
      s_q.misc <= RST_MISC;
      s_q.meter <= RST_ZERO;
      s_q.res_fwd <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // the low nibble comes from each port's own configuration register
  for (genvar p = 0; p < NPORTS; p++) begin : g_vid
    svm_vid_join u_join (
      .sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .vid_hi_in(vid_hi_all[p]),
      .vid_lo_in(port_vid_low_in[p*4 +: 4]),
      .vid_out(vid_all[p*12 +: 12])
    );
  end

  for (genvar m = 0; m < NMETER; m++) begin : g_meter
    svm_meter_gate u_gate (
      .sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .field_in(s_q.meter[m*METER_FIELD_W +: METER_FIELD_W]),
      .enable_in(bw_enable_in[m]),
      .rate_kbps_out(meter_rate_kbps_out[m*RATE_W +: RATE_W]),
      .active_out(meter_active_out[m]),
      .count_len_out(count_len_out[m])
    );
  end

  assign port_default_vlan_id_out = vid_all;
  assign rdata_out = s_q.rdata;
  assign group_ports_out = s_q.grp;
  assign vlan_group_key_out = s_q.key;
  assign dest_result_valid_out = s_q.res_valid;
  assign dest_reserved_out = s_q.res_rsv;
  assign dest_forward_out = s_q.res_fwd;
  assign transceiver_restart_out = s_q.restart_p;
  // only a level to the mii clock logic; the clock itself lives elsewhere
  assign mii_speed_double_out = s_q.misc[MISC_MII_DOUBLE];
  assign collision_indicator_led_out = s_q.led;
  assign port4_led_mode_out = s_q.misc[MISC_P4_LED];
  assign clone_mode_out = {s_q.misc[MISC_CLONE_HI], s_q.clone0};
  assign vlan_identifier_learning_key_out = s_q.learn_key;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!nrst_in);

  sequence s_write_meter;
    wr_in && addr_in == OFS_METER;
  endsequence
  sequence s_read_meter;
    rd_in && addr_in == OFS_METER && !wr_in;
  endsequence
  // steps shared by the write-then-observe checks
  sequence s_restart_cmd;
    wr_in && addr_in == OFS_RESTART && wdata_in == RESTART_CMD;
  endsequence
  sequence s_write_p0_vid;
    wr_in && addr_in == OFS_P0_VID_HI;
  endsequence
  sequence s_write_p5_vid;
    wr_in && addr_in == OFS_P5_SHIFT_DA;
  endsequence

  a_meter_readback: assert property (
    s_write_meter ##1 s_read_meter |=> rdata_out == $past(wdata_in, 2))
    else $error("meter register did not read back");
  a_ro_byte_zero: assert property (
    $past(rd_in) && $past(addr_in) == OFS_P0_VID_HI |-> rdata_out[15:8] == 8'h00)
    else $error("read-only byte not zero");
  a_restart_pulse: assert property (
    s_restart_cmd |=> transceiver_restart_out ##1
      transceiver_restart_out == $past(wr_in && addr_in == OFS_RESTART && wdata_in == RESTART_CMD))
    else $error("restart pulse missing");
  a_restart_quiet: assert property (
    !(wr_in && addr_in == OFS_RESTART && wdata_in == RESTART_CMD) |=> !transceiver_restart_out)
    else $error("spurious restart pulse");
  a_group_map: assert property (
    ##1 group_ports_out == {$past(group_map_in[8]), $past(group_map_in[7]),
      $past(group_map_in[6]), $past(group_map_in[4]), $past(group_map_in[2]),
      $past(group_map_in[0])})
    else $error("group port map wrong");
  a_group_key: assert property (
    ##1 vlan_group_key_out == 4'($past(frame_vid_in) >> $past(s_q.shift_da[10:8])))
    else $error("group key selection wrong");
  a_da_00_policy: assert property (
    dest_valid_in && dest_addr_in == {RSV_DA_PREFIX, DA_LAST_00}
    |=> dest_reserved_out && dest_forward_out == $past(s_q.shift_da[DA_FWD_00]))
    else $error("address 00 policy wrong");
  a_da_01_policy: assert property (
    dest_valid_in && dest_addr_in == {RSV_DA_PREFIX, DA_LAST_01}
    |=> dest_forward_out == $past(s_q.shift_da[DA_FWD_01]))
    else $error("address 01 policy wrong");
  a_da_range_hi: assert property (
    dest_valid_in && dest_addr_in[47:8] == RSV_DA_PREFIX && dest_addr_in[7:0] >= DA_LAST_10
    |=> dest_forward_out == $past(s_q.shift_da[DA_FWD_HI_RANGE]))
    else $error("high reserved range policy wrong");
  a_da_range_lo: assert property (
    dest_valid_in && dest_addr_in[47:8] == RSV_DA_PREFIX && dest_addr_in[7:0] > DA_LAST_01
    && dest_addr_in[7:0] <= DA_LAST_0F
    |=> dest_forward_out == $past(s_q.shift_da[DA_FWD_LO_RANGE]))
    else $error("low reserved range policy wrong");
  a_dual_hub_led: assert property (
    s_q.misc[MISC_DUAL_HUB] |=> collision_indicator_led_out == {$past(col_100m_in),
      $past(col_10m_in)})
    else $error("dual hub led mapping wrong");
  a_clone_key: assert property (
    clone_bit0_in || s_q.misc[MISC_CLONE_HI]
    |=> vlan_identifier_learning_key_out == $past(frame_vid_in))
    else $error("clone learning key wrong");
  a_mii_double: assert property (
    wr_in && addr_in == OFS_MISC |=> mii_speed_double_out == $past(wdata_in[6]))
    else $error("speed double bit not taken");
  a_p4_vid: assert property (
    wr_in && addr_in == OFS_P34_VID_HI
    |=> ##1 port_default_vlan_id_out[4*12+4 +: 8] == $past(wdata_in[15:8], 2))
    else $error("port 4 vid high byte wrong");

  // read data stand one cycle, then fall back to zero
  a_rdata_idle: assert property (
    !rd_in |=> rdata_out == '0)
    else $error("read data left standing");
  a_unmapped_read: assert property (
    rd_in && (addr_in < OFS_RSV_A_FIRST || addr_in > OFS_METER) |=> rdata_out == '0)
    else $error("unmapped read not zero");
  a_ro_byte_p1: assert property (
    rd_in && addr_in == OFS_P1_VID_HI |=> rdata_out[15:8] == 8'h00)
    else $error("port 1 read-only byte not zero");
  a_ro_byte_p2: assert property (
    rd_in && addr_in == OFS_P2_VID_HI |=> rdata_out[15:8] == 8'h00)
    else $error("port 2 read-only byte not zero");
  // vid outputs lag a write by two edges: bank register, then join flop
  a_p0_vid: assert property (
    s_write_p0_vid |=> ##1 port_default_vlan_id_out[4 +: 8] == $past(wdata_in[7:0], 2))
    else $error("port 0 vid high byte wrong");
  a_p5_vid: assert property (
    s_write_p5_vid |=> ##1 port_default_vlan_id_out[5*12+4 +: 8] == $past(wdata_in[7:0], 2))
    else $error("port 5 vid high byte wrong");
  a_dest_valid_copy: assert property (
    ##1 dest_result_valid_out == $past(dest_valid_in))
    else $error("classifier result valid lost");
  // a miss on the reserved prefix always forwards
  a_da_not_reserved: assert property (
    !(dest_valid_in && dest_addr_in[47:8] == RSV_DA_PREFIX)
    |=> !dest_reserved_out && dest_forward_out)
    else $error("ordinary address classified as reserved");
  a_normal_led: assert property (
    !s_q.misc[MISC_DUAL_HUB] |=> collision_indicator_led_out == $past(port_col_in))
    else $error("normal led mapping wrong");
  // outside clone mode the key stays zero so learning ignores the vid
  a_clone_key_off: assert property (
    !clone_bit0_in && !s_q.misc[MISC_CLONE_HI]
    |=> vlan_identifier_learning_key_out == '0)
    else $error("learning key used outside clone mode");
  a_clone_mode_bits: assert property (
    ##1 clone_mode_out == {s_q.misc[MISC_CLONE_HI], $past(clone_bit0_in)})
    else $error("clone mode bits wrong");
endmodule

// File: bench/tb_top.sv
// self-checking bench for the vlan and meter configuration bank
module tb_top import svm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [AW-1:0] addr_in = '0;
  logic [DW-1:0] wdata_in = '0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [NPORTS*4-1:0] port_vid_low_in = '0;
  logic [8:0] group_map_in = '0;
  logic [11:0] frame_vid_in = '0;
  logic [47:0] dest_addr_in = '0;
  logic dest_valid_in = 1'b0;
  logic clone_bit0_in = 1'b0;
  logic [NMETER-1:0] bw_enable_in = '0;
  logic col_10m_in = 1'b0;
  logic col_100m_in = 1'b0;
  logic [1:0] port_col_in = '0;
  logic [DW-1:0] rdata_out;
  logic [NPORTS*12-1:0] port_default_vlan_id_out;
  logic [NPORTS-1:0] group_ports_out;
  logic [3:0] vlan_group_key_out;
  logic dest_result_valid_out, dest_reserved_out, dest_forward_out, transceiver_restart_out;
  logic mii_speed_double_out, port4_led_mode_out;
  logic [1:0] collision_indicator_led_out, clone_mode_out;
  logic [11:0] vlan_identifier_learning_key_out;
  logic [NMETER*RATE_W-1:0] meter_rate_kbps_out;
  logic [NMETER-1:0] meter_active_out, count_len_out;
  int failures = 0;
  int checks_done = 0;

  always #10 sys_clk_in = ~sys_clk_in;

  svm_bank dut_u (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .port_vid_low_in(port_vid_low_in), .group_map_in(group_map_in),
    .frame_vid_in(frame_vid_in), .dest_addr_in(dest_addr_in), .dest_valid_in(dest_valid_in),
    .clone_bit0_in(clone_bit0_in), .bw_enable_in(bw_enable_in), .col_10m_in(col_10m_in),
    .col_100m_in(col_100m_in), .port_col_in(port_col_in),
    .port_default_vlan_id_out(port_default_vlan_id_out), .group_ports_out(group_ports_out),
    .vlan_group_key_out(vlan_group_key_out), .dest_result_valid_out(dest_result_valid_out),
    .dest_reserved_out(dest_reserved_out), .dest_forward_out(dest_forward_out),
    .transceiver_restart_out(transceiver_restart_out), .mii_speed_double_out(mii_speed_double_out),
    .collision_indicator_led_out(collision_indicator_led_out),
    .port4_led_mode_out(port4_led_mode_out), .clone_mode_out(clone_mode_out),
    .vlan_identifier_learning_key_out(vlan_identifier_learning_key_out),
    .meter_rate_kbps_out(meter_rate_kbps_out), .meter_active_out(meter_active_out),
    .count_len_out(count_len_out));

  task automatic chk(input string name, input logic [71:0] exp, input logic [71:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask

  // read data are taken only in the single cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), exp, rdata_out);
  endtask

  // write then read the same register with no gap between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1;
    chk($sformatf("reg %h after write", a), d, rdata_out);
  endtask

  // three edges cover the two-flop path from a write to the vid outputs
  task automatic settle;
    repeat (3) @(posedge sys_clk_in);
    #1;
  endtask

  task automatic t_reset;
    rd_chk(8'h23, 16'h0000);
    rd_chk(8'h28, 16'h0000);
    rd_chk(8'h2c, 16'hb000);
    rd_chk(8'h2d, 16'h4442);
    rd_chk(8'h2f, 16'h0000);
    rd_chk(8'h30, 16'h0987);
    rd_chk(8'h31, 16'h0000);
  endtask

  task automatic t_rw;
    bus_wr(8'h23, 16'ha5c3);
    bus_wr(8'h27, 16'h5a3c);
    bus_wr(8'h2e, 16'h1bd2);
    bus_wr(8'h28, 16'hff12);
    bus_wr(8'h22, 16'hffff);
    rd_chk(8'h23, 16'ha5c3);
    rd_chk(8'h27, 16'h5a3c);
    rd_chk(8'h2e, 16'h1bd2);
    rd_chk(8'h28, 16'h0012);
    rd_chk(8'h22, 16'h0000);
    rd_chk(8'h32, 16'h0000);
    @(posedge sys_clk_in);
    #1;
    chk("rdata idle", 16'h0000, rdata_out);
  endtask

  task automatic t_vid;
    logic [7:0] hi [NPORTS];
    logic [71:0] exp;
    hi = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9a, 8'hbc};
    bus_wr(8'h29, 16'hc334);
    bus_wr(8'h2a, 16'h7e56);
    bus_wr(8'h2b, 16'h9a78);
    bus_wr(8'h2c, 16'hb0bc);
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk_in);
      port_vid_low_in <= k ? 24'h012345 : 24'hfedcba;
      settle();
      for (int p = 0; p < NPORTS; p++) begin
        exp[12*p+:12] = {hi[p], 4'((k ? 24'h012345 : 24'hfedcba) >> (4 * p))};
      end
      chk("port vid", exp, port_default_vlan_id_out);
    end
    rd_chk(8'h2b, 16'h9a78);
    rd_chk(8'h29, 16'h0034);
    rd_chk(8'h2a, 16'h0056);
  endtask

  task automatic t_group;
    logic [11:0] v;
    v = 12'h5a3;
    @(posedge sys_clk_in);
    group_map_in <= 9'h1a5;
    frame_vid_in <= v;
    settle();
    chk("group ports", 6'h33, group_ports_out);
    @(posedge sys_clk_in);
    group_map_in <= 9'h054;
    settle();
    chk("group ports", 6'h0e, group_ports_out);
    for (int n = 0; n < 8; n++) begin
      bus_wr(8'h2c, 16'hb0bc | (16'(n) << 8));
      settle();
      chk("group key", v[n+:4], vlan_group_key_out);
    end
  endtask

  task automatic probe(input logic [7:0] last, input logic er, input logic ef);
    @(posedge sys_clk_in);
    dest_addr_in <= er ? {RSV_DA_PREFIX, last} : {40'h0180c20001, last};
    dest_valid_in <= 1'b1;
    @(posedge sys_clk_in);
    dest_valid_in <= 1'b0;
    #1;
    chk($sformatf("dest %h valid", last), 1'b1, dest_result_valid_out);
    chk($sformatf("dest %h reserved", last), er, dest_reserved_out);
    chk($sformatf("dest %h forward", last), ef, dest_forward_out);
    @(posedge sys_clk_in);
    #1;
    chk("dest valid idle", 1'b0, dest_result_valid_out);
  endtask

  task automatic t_dest;
    logic [3:0] p;
    for (int k = 0; k < 2; k++) begin
      p = k ? 4'h4 : 4'hb;
      bus_wr(8'h2c, {p, 12'h0bc});
      probe(8'h00, 1'b1, p[3]);
      probe(8'h01, 1'b1, p[2]);
      probe(8'h02, 1'b1, p[1]);
      probe(8'h0f, 1'b1, p[1]);
      probe(8'h10, 1'b1, p[0]);
      probe(8'hff, 1'b1, p[0]);
      probe(8'h00, 1'b0, 1'b1);
    end
  endtask

  task automatic t_restart;
    bus_wr(8'h2f, 16'h1234);
    #1;
    chk("restart nonzero", 1'b0, transceiver_restart_out);
    rd_chk(8'h2f, 16'h1234);
    // two zero writes back to back must give two adjacent pulses
    @(posedge sys_clk_in);
    addr_in <= 8'h2f;
    wdata_in <= 16'h0000;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    #1;
    chk("restart first", 1'b1, transceiver_restart_out);
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
    #1;
    chk("restart second", 1'b1, transceiver_restart_out);
    @(posedge sys_clk_in);
    #1;
    chk("restart end", 1'b0, transceiver_restart_out);
  endtask

  task automatic t_misc;
    logic [15:0] d;
    @(posedge sys_clk_in);
    col_10m_in <= 1'b1;
    port_col_in <= 2'b10;
    for (int k = 0; k < 2; k++) begin
      d = k ? 16'h0000 : 16'h1260;
      bus_wr(8'h30, d);
      settle();
      chk("speed double", d[6], mii_speed_double_out);
      chk("col leds", d[9] ? 2'b01 : 2'b10, collision_indicator_led_out);
      chk("port4 led", d[12], port4_led_mode_out);
      chk("clone mode", {d[5], 1'b0}, clone_mode_out);
      chk("learn key", d[5] ? 12'h5a3 : 12'h000, vlan_identifier_learning_key_out);
      rd_chk(8'h30, d);
    end
    @(posedge sys_clk_in);
    clone_bit0_in <= 1'b1;
    settle();
    chk("clone mode", 2'b01, clone_mode_out);
    chk("learn key", 12'h5a3, vlan_identifier_learning_key_out);
  endtask

  task automatic t_meter;
    logic [16:0] rt [8];
    logic [15:0] d;
    logic [3:0] e, cl;
    logic [NMETER*RATE_W-1:0] r;
    rt = '{17'h00100, 17'h00200, 17'h003e8, 17'h007d0, 17'h01388, 17'h02710, 17'h04e20,
           17'h0c350};
    for (int c = 0; c < 8; c++) begin
      e = c[0] ? 4'h6 : 4'hb;
      for (int m = 0; m < NMETER; m++) begin
        d[4*m+:4] = {1'(m ^ c), 3'(c + m)};
        r[RATE_W*m+:RATE_W] = e[m] ? rt[3'(c + m)] : 17'h00000;
        cl[m] = ~d[4*m+3];
      end
      @(posedge sys_clk_in);
      bw_enable_in <= e;
      wr_rd(8'h31, d);
      settle();
      chk("meter rate", r, meter_rate_kbps_out);
      chk("meter active", e, meter_active_out);
      chk("count length", cl, count_len_out);
      rd_chk(8'h31, d);
    end
  endtask

  task automatic final_report;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    failures++;
    final_report();
  end

  initial begin
    repeat (10) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    t_reset();
    t_rw();
    t_vid();
    t_group();
    t_dest();
    t_restart();
    t_misc();
    t_meter();
    final_report();
  end
endmodule
